// ==== inc/plbm_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the port latch block
//
// Overview of operation
// - Port zero has no internal pull-up in port mode, so a released pin floats and only the pull-down drives it.
// - The port zero high-side driver is enabled only while port zero serves as the external address/data bus.
// - The port zero latch is a bit-addressable register at address 80h, bit n controlling pin n.
// - On ports zero to three a latch bit of 0 turns the pull-down on and a 1 turns it off.
// - Writing 1 to a port one latch bit presents a high on the pin and makes the pin usable as an input.
// - Port two drives address lines A8 to A15 when external access is low at reset or during an external data move.
// - The port zero output stage is multiplexed between its latch and the low address byte shared with data.
// - The port two output stage is multiplexed between its latch and the high address byte.
// - In bus mode both latches are cut from the pins, port zero latch forced to all ones, port two latch held.
// - When port zero is used as an external bus input its latch outputs are forced to 1.
// - The port one, two and three latches are bit-addressable registers at 90h, A0h and B0h.
// - Port one carries timer two count and aux inputs on bits 0 and 1, pulse outputs on 2 and 3, SCL on 6, SDA on 7.
// - A port three pin works as input or passes its alternate function only while its latch bit is 1.
// - On reset every latch bit is set so that all pins come up as inputs.
// - Read-modify-write accesses read the latch value, all other port reads sample the pin level; the code samples pins at 80h-B0h and reads latches at C0h-CCh.
// - A new latch value appears at the latch output on the edge that ends the writing access, so in the cycle after it.
`ifndef PLBM_REGS_SVH
`define PLBM_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PLBM_ADDR_PORT0_LATCH 8'h80
`define PLBM_ADDR_PORT1_LATCH 8'h90
`define PLBM_ADDR_PORT2_LATCH 8'ha0
`define PLBM_ADDR_PORT3_LATCH 8'hb0
`define PLBM_ADDR_LATCH_VIEW0 8'hc0
`define PLBM_ADDR_LATCH_VIEW1 8'hc4
`define PLBM_ADDR_LATCH_VIEW2 8'hc8
`define PLBM_ADDR_LATCH_VIEW3 8'hcc
`define PLBM_ADDR_BIT_ACCESS 8'hd0
`define PLBM_ADDR_STATUS 8'hd4

// ----------------------------------------------------------------------------
// Field positions of the bit access and status registers
// ----------------------------------------------------------------------------
`define PLBM_BIT_SEL_LO 0
`define PLBM_BIT_SEL_HI 2
`define PLBM_BIT_PORT_LO 3
`define PLBM_BIT_PORT_HI 4
`define PLBM_BIT_VALUE 8
`define PLBM_STAT_STRAP 0
`define PLBM_STAT_BUS 1

// ----------------------------------------------------------------------------
// Reset values and sync depth
// ----------------------------------------------------------------------------
`define PLBM_LATCH_RESET 8'hff
`define PLBM_PIN_IDLE 1'b1
`define PLBM_SYNC_STAGES 2

`endif

// ==== inc/plbm_pkg.sv ====
// Types shared by the port latch block
`default_nettype none

package plbm_pkg;

  // Strap capture phase after reset release
  typedef enum logic [1:0] {
    PLBM_STRAP_SYNC = 2'b00,
    PLBM_STRAP_FILL = 2'b11,
    PLBM_STRAP_TAKE = 2'b01,
    PLBM_RUN = 2'b10
  } plbm_phase_e;

  // One byte per port
  typedef logic [3:0][7:0] plbm_ports_t;

  // All state of the top module
  typedef struct packed {
    plbm_phase_e phase;
    logic eaStrap;
    plbm_ports_t latch;
    plbm_ports_t pinOut;
    plbm_ports_t pinOe;
    logic [31:0] prdata;
    logic pslverr;
  } plbm_state_s;

endpackage : plbm_pkg

`default_nettype wire

// ==== rtl/plbm_sync.sv ====
// Two-stage synchroniser for pin inputs, one generate slice per bit
`include "plbm_regs.svh"
`default_nettype none

module plbm_sync #(
  parameter int WIDTH = 33
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // ----------------------------------------------------------------------------
  // Per-bit flop pair
  // ----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic [`PLBM_SYNC_STAGES-1:0] stage_r;
      // First flop feeds only the second
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stage_r <= {`PLBM_SYNC_STAGES{`PLBM_PIN_IDLE}};
        end else begin
          stage_r <= {stage_r[0], asyncIn[i]};
        end
      end
      assign syncOut[i] = stage_r[`PLBM_SYNC_STAGES-1];
    end
  endgenerate

endmodule : plbm_sync

`default_nettype wire

// ==== rtl/plbm_top.sv ====
// Port latches, pin drivers and external bus multiplexer behind an APB slave
`include "plbm_regs.svh"
`default_nettype none

module plbm_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External access strap pin, low selects external bus
  input wire logic externalAccessSelectN,
  // External bus from the core
  input wire logic externalDataMove,
  input wire logic [7:0] extLowOut,
  input wire logic extLowDrive,
  input wire logic [7:0] extAddrHigh,
  output logic [7:0] extDataIn,
  output logic busMode,
  // Port zero pins, open drain with bus high-side
  input wire logic [7:0] portZeroIn,
  output logic [7:0] portZeroOut,
  output logic [7:0] portZeroOe,
  // Port one pins, quasi-bidirectional
  input wire logic [7:0] portOneIn,
  output logic [7:0] portOneOut,
  output logic [7:0] portOneOe,
  // Port two pins, quasi-bidirectional with address high-side
  input wire logic [7:0] portTwoIn,
  output logic [7:0] portTwoOut,
  output logic [7:0] portTwoOe,
  // Port three pins, quasi-bidirectional
  input wire logic [7:0] portThreeIn,
  output logic [7:0] portThreeOut,
  output logic [7:0] portThreeOe,
  // Port one alternate functions, outputs high means released
  input wire logic pulseWidthOutA,
  input wire logic pulseWidthOutB,
  input wire logic i2cSclOut,
  input wire logic i2cSdaOut,
  output logic timerTwoCountInput,
  output logic timerTwoAuxInput,
  output logic i2cSclIn,
  output logic i2cSdaIn,
  // Port three alternate functions
  input wire logic [7:0] portThreeAltOut,
  output logic [7:0] portThreeAltIn
);

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  logic [32:0] syncOut;
  plbm_pkg::plbm_ports_t portSync;
  logic eaSync;

  plbm_sync #(
    .WIDTH(33)
  ) plbm_sync_i (
    .clk(clk),
    .rst(rst),
    .asyncIn({externalAccessSelectN, portThreeIn, portTwoIn, portOneIn, portZeroIn}),
    .syncOut(syncOut)
  );

  // Split synchronised levels per port
  assign portSync = syncOut[31:0];
  assign eaSync = syncOut[32];

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  plbm_pkg::plbm_state_s s_r;
  plbm_pkg::plbm_state_s s_nxt;
  logic [31:0] rdVal;
  logic addrHit;
  logic wrAccess;
  logic [7:0] portOneAlt;
  logic [1:0] bitPort;
  logic [2:0] bitSel;

  // Bus mode from strap or a running data move
  assign busMode = !s_r.eaStrap || externalDataMove;

  // Write taken at the access-phase edge
  assign wrAccess = psel && penable && pwrite && pstrb[0];

  // Bit access fields
  assign bitPort = pwdata[`PLBM_BIT_PORT_HI:`PLBM_BIT_PORT_LO];
  assign bitSel = pwdata[`PLBM_BIT_SEL_HI:`PLBM_BIT_SEL_LO];

  // Port one alternate outputs, 1 where no function drives
  assign portOneAlt = {i2cSdaOut, i2cSclOut, 2'b11, pulseWidthOutB, pulseWidthOutA, 2'b11};

  // ----------------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------------
  // Printed offsets sample pins, view offsets return latches
  always_comb begin
    rdVal = 32'h0000_0000;
    addrHit = 1'b1;
    case (paddr)
      `PLBM_ADDR_PORT0_LATCH: rdVal[7:0] = portSync[0];
      `PLBM_ADDR_PORT1_LATCH: rdVal[7:0] = portSync[1];
      `PLBM_ADDR_PORT2_LATCH: rdVal[7:0] = portSync[2];
      `PLBM_ADDR_PORT3_LATCH: rdVal[7:0] = portSync[3];
      `PLBM_ADDR_LATCH_VIEW0: rdVal[7:0] = s_r.latch[0];
      `PLBM_ADDR_LATCH_VIEW1: rdVal[7:0] = s_r.latch[1];
      `PLBM_ADDR_LATCH_VIEW2: rdVal[7:0] = s_r.latch[2];
      `PLBM_ADDR_LATCH_VIEW3: rdVal[7:0] = s_r.latch[3];
      `PLBM_ADDR_BIT_ACCESS: rdVal = 32'h0000_0000;
      `PLBM_ADDR_STATUS: begin
        rdVal[`PLBM_STAT_STRAP] = s_r.eaStrap;
        rdVal[`PLBM_STAT_BUS] = busMode;
      end
      default: addrHit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Two edges for the synchroniser to fill, then strap capture
    case (s_r.phase)
      plbm_pkg::PLBM_STRAP_SYNC: s_nxt.phase = plbm_pkg::PLBM_STRAP_FILL;
      plbm_pkg::PLBM_STRAP_FILL: s_nxt.phase = plbm_pkg::PLBM_STRAP_TAKE;
      plbm_pkg::PLBM_STRAP_TAKE: begin
        s_nxt.eaStrap = eaSync;
        s_nxt.phase = plbm_pkg::PLBM_RUN;
      end
      plbm_pkg::PLBM_RUN: s_nxt.phase = plbm_pkg::PLBM_RUN;
      default: s_nxt.phase = plbm_pkg::PLBM_RUN;
    endcase
    // Read data and error latched in the setup cycle
    if (psel && !penable) begin
      s_nxt.prdata = rdVal;
      s_nxt.pslverr = !addrHit;
    end
    // Byte and bit writes to the latches
    if (wrAccess) begin
      case (paddr)
        `PLBM_ADDR_PORT0_LATCH: s_nxt.latch[0] = pwdata[7:0];
        `PLBM_ADDR_PORT1_LATCH: s_nxt.latch[1] = pwdata[7:0];
        `PLBM_ADDR_PORT2_LATCH: s_nxt.latch[2] = pwdata[7:0];
        `PLBM_ADDR_PORT3_LATCH: s_nxt.latch[3] = pwdata[7:0];
        `PLBM_ADDR_BIT_ACCESS: s_nxt.latch[bitPort][bitSel] = pwdata[`PLBM_BIT_VALUE];
        default: s_nxt.latch = s_r.latch;
      endcase
    end
    // Bus mode forces port zero latch high and freezes port two
    if (busMode) begin
      s_nxt.latch[0] = `PLBM_LATCH_RESET;
      s_nxt.latch[2] = s_r.latch[2];
    end
    // Port zero: bus drives both levels, port mode only pulls down
    if (busMode) begin
      s_nxt.pinOut[0] = extLowOut;
      s_nxt.pinOe[0] = {8{extLowDrive}};
    end else begin
      s_nxt.pinOut[0] = 8'h00;
      s_nxt.pinOe[0] = ~s_nxt.latch[0];
    end
    // Port one: pull-down on latch 0 or alternate low
    s_nxt.pinOut[1] = 8'h00;
    s_nxt.pinOe[1] = ~(s_nxt.latch[1] & portOneAlt);
    // Port two: address high byte in bus mode, else latch
    if (busMode) begin
      s_nxt.pinOut[2] = extAddrHigh;
      s_nxt.pinOe[2] = 8'hff;
    end else begin
      s_nxt.pinOut[2] = 8'h00;
      s_nxt.pinOe[2] = ~s_nxt.latch[2];
    end
    // Port three: alternate outputs pass only through a latch 1
    s_nxt.pinOut[3] = 8'h00;
    s_nxt.pinOe[3] = ~(s_nxt.latch[3] & portThreeAltOut);
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.phase <= plbm_pkg::PLBM_STRAP_SYNC;
      s_r.eaStrap <= 1'b1;
      s_r.latch <= {4{`PLBM_LATCH_RESET}};
      s_r.pinOut <= 32'h0000_0000;
      s_r.pinOe <= 32'h0000_0000;
      s_r.prdata <= 32'h0000_0000;
      s_r.pslverr <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // APB answer in the first access cycle
  assign pready = psel && penable;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr && psel && penable;

  // Pin drivers from flops
  assign portZeroOut = s_r.pinOut[0];
  assign portZeroOe = s_r.pinOe[0];
  assign portOneOut = s_r.pinOut[1];
  assign portOneOe = s_r.pinOe[1];
  assign portTwoOut = s_r.pinOut[2];
  assign portTwoOe = s_r.pinOe[2];
  assign portThreeOut = s_r.pinOut[3];
  assign portThreeOe = s_r.pinOe[3];

  // Peripheral and core inputs from synchronised pins
  assign extDataIn = portSync[0];
  assign timerTwoCountInput = portSync[1][0];
  assign timerTwoAuxInput = portSync[1][1];
  assign i2cSclIn = portSync[1][6];
  assign i2cSdaIn = portSync[1][7];
  assign portThreeAltIn = portSync[3] & s_r.latch[3];

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Write access to port one latch
  sequence portOneWrite;
    wrAccess && paddr == `PLBM_ADDR_PORT1_LATCH;
  endsequence

  // Setup cycle of a pin read of port one
  sequence portOneRead;
    psel && !penable && paddr == `PLBM_ADDR_PORT1_LATCH;
  endsequence

  p0_no_pullup_a: assert property (!busMode |=> portZeroOut == 8'h00)
    else $error("port zero drives high outside bus mode");
  p0_high_side_a: assert property (portZeroOut != 8'h00 |-> $past(busMode))
    else $error("port zero high-side on outside bus mode");
  p0_forced_a: assert property (busMode |=> s_r.latch[0] == 8'hff)
    else $error("port zero latch not forced high in bus mode");
  p2_hold_a: assert property (busMode |=> $stable(s_r.latch[2]))
    else $error("port two latch changed in bus mode");
  p2_address_a: assert property (busMode |=> portTwoOe == 8'hff && portTwoOut == $past(extAddrHigh))
    else $error("port two not carrying high address");
  pull_down_a: assert property ((~s_r.latch[1] & ~portOneOe) == 8'h00)
    else $error("port one latch zero without pull-down");
  p3_gate_a: assert property ((portThreeAltIn & ~s_r.latch[3]) == 8'h00)
    else $error("port three alternate input passed with latch zero");
  latch_write_a: assert property (portOneWrite |=> s_r.latch[1] == $past(pwdata[7:0]))
    else $error("port one latch did not take written value");
  pin_read_a: assert property (portOneRead ##1 penable |-> prdata == $past(portSync[1]))
    else $error("port read did not return pin level");
  strap_take_a: assert property (s_r.phase == plbm_pkg::PLBM_STRAP_TAKE |=> s_r.eaStrap == $past(eaSync))
    else $error("strap not captured from synchronised pin");
  p2_release_a: assert property (!busMode |=> portTwoOe == ~s_r.latch[2])
    else $error("port two not back on its latch after bus mode");
  p0_bus_drive_a: assert property (busMode |=> portZeroOut == $past(extLowOut))
    else $error("port zero not carrying low address or data");
  p1_alt_a: assert property (portOneOe == ~(s_r.latch[1] & $past(portOneAlt)))
    else $error("port one alternate output not on pin");

endmodule : plbm_top

`default_nettype wire

// ==== tb/plbm_pins.sv ====
// Pin and external load model for the four ports
`default_nettype none

module plbm_pins (
  // Pin drive from the block
  input wire plbm_pkg::plbm_ports_t drvOut,
  input wire plbm_pkg::plbm_ports_t drvOe,
  // External parts pulling lines low
  input wire plbm_pkg::plbm_ports_t extPullLow,
  // Resolved line levels
  output var plbm_pkg::plbm_ports_t pinLvl
);
  timeunit 1ns;
  timeprecision 1ns;

  // Released lines rest high: weak pull-ups, board resistor on port zero
  always_comb begin
    pinLvl = ((drvOe & drvOut) | ~drvOe) & ~extPullLow;
  end
endmodule : plbm_pins

`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the port latch block
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------
  // Signals
  // ----------
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, oeAll, outAll;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, busMode, err;
  logic externalAccessSelectN = 1, externalDataMove = 0, extLowDrive = 0;
  logic [7:0] extLowOut = 8'h00, extAddrHigh = 8'h00, extDataIn;
  logic [7:0] portZeroIn, portZeroOut, portZeroOe, portOneIn, portOneOut, portOneOe;
  logic [7:0] portTwoIn, portTwoOut, portTwoOe, portThreeIn, portThreeOut, portThreeOe;
  logic pulseWidthOutA = 1, pulseWidthOutB = 1, i2cSclOut = 1, i2cSdaOut = 1;
  logic timerTwoCountInput, timerTwoAuxInput, i2cSclIn, i2cSdaIn;
  logic [7:0] portThreeAltOut = 8'hff, portThreeAltIn;
  plbm_pkg::plbm_ports_t pullLow = '0, lvl;
  int badCount = 0, totalChecks = 0, cyc = 0;

  always #50 clk = ~clk;

  plbm_top plbm_top_i (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .externalAccessSelectN, .externalDataMove, .extLowOut, .extLowDrive, .extAddrHigh, .extDataIn,
    .busMode, .portZeroIn, .portZeroOut, .portZeroOe, .portOneIn, .portOneOut, .portOneOe,
    .portTwoIn, .portTwoOut, .portTwoOe, .portThreeIn, .portThreeOut, .portThreeOe,
    .pulseWidthOutA, .pulseWidthOutB, .i2cSclOut, .i2cSdaOut, .timerTwoCountInput,
    .timerTwoAuxInput, .i2cSclIn, .i2cSdaIn, .portThreeAltOut, .portThreeAltIn
  );
  plbm_pins plbm_pins_i (.drvOut(outAll), .drvOe(oeAll), .extPullLow(pullLow), .pinLvl(lvl));
  assign oeAll = {portThreeOe, portTwoOe, portOneOe, portZeroOe};
  assign outAll = {portThreeOut, portTwoOut, portOneOut, portZeroOut};
  assign {portThreeIn, portTwoIn, portOneIn, portZeroIn} = lvl;

  // ----------
  // Shared tasks
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask : apb

  task automatic doReset(input logic strapN);
    @(posedge clk);
    rst <= 1;
    externalAccessSelectN <= strapN;
    repeat (16) @(posedge clk);
    rst <= 0;
    tick(4);
  endtask : doReset

  // ----------
  // Scenarios
  // ----------
  task automatic tReset;
    chk(oeAll, 32'h0);
    for (int p = 0; p < 4; p++) begin
      apb(0, 8'hc0 + 8'(4 * p), 32'h0);
      chk(rd, 32'hff);
    end
  endtask : tReset

  task automatic tWrite;
    logic [7:0] addr [4] = '{8'h80, 8'h90, 8'ha0, 8'hb0};
    logic [7:0] pat;
    for (int p = 0; p < 4; p++) begin
      pat = {4'(p + 5), 4'h9};
      apb(1, addr[p], {24'h0, pat});
      chk(32'(oeAll[p*8 +: 8]), {24'h0, ~pat});
      chk(32'(outAll[p*8 +: 8]), 32'h0);
      tick(3);
      apb(0, addr[p], 32'h0);
      chk(rd, {24'h0, pat});
      apb(0, 8'hc0 + 8'(4 * p), 32'h0);
      chk(rd, {24'h0, pat});
    end
  endtask : tWrite

  // Port one inputs, alternate functions, bit access, masked write
  task automatic tPortOne;
    apb(1, 8'h90, 32'hff);
    @(posedge clk);
    pullLow[1] <= 8'h0d;
    pulseWidthOutA <= 0;
    pulseWidthOutB <= 0;
    tick(4);
    chk(portOneOe, 8'h0c);
    chk({timerTwoCountInput, timerTwoAuxInput, i2cSclIn}, 3'b011);
    apb(0, 8'h90, 32'h0);
    chk(rd, 32'hf2);
    apb(0, 8'hc4, 32'h0);
    chk(rd, 32'hff);
    @(posedge clk);
    pullLow[1] <= 8'h00;
    pulseWidthOutA <= 1;
    pulseWidthOutB <= 1;
    i2cSdaOut <= 0;
    tick(4);
    chk({portOneOe, 7'h0, i2cSdaIn}, 16'h8000);
    @(posedge clk);
    i2cSdaOut <= 1;
    apb(1, 8'hd0, 32'h0b);
    pstrb <= 4'h0;
    apb(1, 8'h90, 32'h00);
    pstrb <= 4'hf;
    apb(0, 8'hc4, 32'h0);
    chk(rd, 32'hf7);
    apb(0, 8'h44, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
  endtask : tPortOne

  task automatic tPortThree;
    apb(1, 8'hb0, 32'h7f);
    @(posedge clk);
    portThreeAltOut <= 8'hfe;
    tick(4);
    chk(portThreeOe, 8'h81);
    chk(portThreeAltIn, 8'h7e);
    @(posedge clk);
    portThreeAltOut <= 8'hff;
  endtask : tPortThree

  // External data move over a latch holding 0x79 on port two
  task automatic tBus;
    @(posedge clk);
    externalDataMove <= 1;
    extAddrHigh <= 8'h3c;
    extLowOut <= 8'ha5;
    extLowDrive <= 1;
    tick(2);
    chk({busMode, portTwoOe, portTwoOut}, 17'h1ff3c);
    chk({portZeroOe, portZeroOut}, 16'hffa5);
    apb(1, 8'ha0, 32'h0);
    apb(0, 8'hc0, 32'h0);
    chk(rd, 32'hff);
    apb(0, 8'hc8, 32'h0);
    chk(rd, 32'h79);
    @(posedge clk);
    extLowDrive <= 0;
    pullLow[0] <= 8'h33;
    tick(4);
    chk(portZeroOe, 8'h00);
    chk(extDataIn, 8'hcc);
    @(posedge clk);
    pullLow[0] <= 8'h00;
    externalDataMove <= 0;
    tick(1);
    chk({busMode, portTwoOe}, 9'h086);
  endtask : tBus

  task automatic tStrap;
    doReset(1'b0);
    chk({busMode, portTwoOe, portTwoOut}, 17'h1ff3c);
    apb(0, 8'hd4, 32'h0);
    chk(rd, 32'h2);
    doReset(1'b1);
    chk(32'(busMode), 32'h0);
    chk(oeAll, 32'h0);
  endtask : tStrap

  // ----------
  // Run control
  // ----------
  task automatic close_out;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      close_out();
    end
  end

  initial begin
    doReset(1'b1);
    tReset();
    tWrite();
    tPortOne();
    tPortThree();
    tBus();
    tStrap();
    close_out();
  end
endmodule : tb_top

`default_nettype wire
